// *** hw/adcpsc_top.sv ***
// Module: pin mode, scan channel sequencing and conversion clock divider
// Operation
// - Pin config top bit set turns band gap reference off; clear turns it on.
// - Pin config low thirteen bits: one puts pin in digital mode, port read on.
// - Pin config bit zero: analog mode, port read off, converter samples pin.
// - Bits 14 and 13 of pin config and scan select read zero.
// - Scan select top bit includes band gap channel in the scan.
// - Scan select low thirteen bits include matching channels in the scan.
// - Conversion clock period is instruction cycle times divider plus one.
// - Divider eight bits; codes above sixty-three are reserved.
`timescale 1ns/1ps
module adcpsc_top
	import adcpsc_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DATA_W-1:0] RDATA,
	// Converter side
	input wire logic SCAN_ENABLE,
	input wire logic CONV_DONE,
	output logic [NUM_CH-1:0] PIN_DIGITAL_SELECT,
	output logic [NUM_CH-1:0] PIN_ANALOG,
	output logic BANDGAP_REF_ENABLE,
	output logic [3:0] SCAN_CHANNEL,
	output logic CONV_CLOCK_TICK
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] pin_config;
		logic [DATA_W-1:0] scan_select;
		logic [DIV_W-1:0] div;
		logic [DIV_W-1:0] div_count;
		logic tick;
		logic [3:0] channel;
		adcpsc_state_t state;
		logic [DATA_W-1:0] rdata;
	} adcpsc_regs_t;

	adcpsc_regs_t r;
	adcpsc_regs_t next_r;
	logic [DATA_W-1:0] scan_mask;
	logic [DIV_W-1:0] div_limit;

	// ----------------------------------------
	// Channel search
	// ----------------------------------------
	// Next selected channel above cur, wrapping; band gap counts as channel 15
	function automatic logic [3:0] adcpsc_next_ch(input logic [DATA_W-1:0] mask,
		input logic [3:0] cur);
		logic [3:0] found;
		logic hit;
		logic [4:0] c;
		found = cur;
		hit = 1'b0;
		for (int i = 1; i <= DATA_W; i++) begin
			c = 5'(cur) + 5'(i);
			if (!hit && mask[c[3:0]]) begin
				found = c[3:0];
				hit = 1'b1;
			end
		end
		return found;
	endfunction : adcpsc_next_ch

	// Lowest selected channel: search upward from just past the top channel
	function automatic logic [3:0] adcpsc_first_ch(input logic [DATA_W-1:0] mask);
		return adcpsc_next_ch(mask, BANDGAP_CHANNEL);
	endfunction : adcpsc_first_ch

	// ----------------------------------------
	// Register helpers
	// ----------------------------------------
	// Unimplemented bits never store, so they always read back zero
	function automatic logic [DATA_W-1:0] adcpsc_impl(input logic [DATA_W-1:0] word);
		return word & IMPL_MASK;
	endfunction : adcpsc_impl

	// Reserved codes saturate at the longest period rather than run off
	function automatic logic [DIV_W-1:0] adcpsc_div_limit(input logic [DIV_W-1:0] code);
		logic [DIV_W-1:0] lim;
		if (code > DIV_MAX) begin
			lim = DIV_MAX;
		end else begin
			lim = code;
		end
		return lim;
	endfunction : adcpsc_div_limit

	// Read-back word for one address; unmapped addresses read zero
	function automatic logic [DATA_W-1:0] adcpsc_read_word(input logic [ADDR_W-1:0] addr,
		input adcpsc_regs_t cur);
		logic [DATA_W-1:0] word;
		word = '0;
		case (addr)
			ADDR_PIN_CONFIG: begin
				word = adcpsc_impl(cur.pin_config);
			end
			ADDR_SCAN_SELECT: begin
				word = adcpsc_impl(cur.scan_select);
			end
			ADDR_CLOCK_DIV: begin
				word[DIV_W-1:0] = cur.div;
			end
			ADDR_SCAN_STATUS: begin
				word[SCAN_BUSY_BIT] = (cur.state == ADCPSC_SCAN);
				word[CH_W-1:0] = cur.channel;
			end
			default: begin
				word = '0;
			end
		endcase
		return word;
	endfunction : adcpsc_read_word

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	assign scan_mask = adcpsc_impl(r.scan_select);
	assign div_limit = adcpsc_div_limit(r.div);

	always_comb begin
		next_r = r;
		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		if (WR) begin
			case (ADDR)
				ADDR_PIN_CONFIG: begin
					next_r.pin_config = adcpsc_impl(WDATA);
				end
				ADDR_SCAN_SELECT: begin
					next_r.scan_select = adcpsc_impl(WDATA);
				end
				ADDR_CLOCK_DIV: begin
					next_r.div = WDATA[DIV_W-1:0];
				end
				default: begin
					// Status and unmapped addresses ignore writes
					next_r.pin_config = r.pin_config;
				end
			endcase
		end
		// ----------------------------------------
		// Register reads
		// ----------------------------------------
		// Read data stand only in the cycle after the strobe
		if (RD) begin
			next_r.rdata = adcpsc_read_word(ADDR, r);
		end else begin
			next_r.rdata = '0;
		end
		// ----------------------------------------
		// Conversion clock divider
		// ----------------------------------------
		// Compare with >= so a shorter code written mid-count ends the period at once
		if (r.div_count >= div_limit) begin
			next_r.div_count = RESET_DIV;
			next_r.tick = 1'b1;
		end else begin
			next_r.div_count = r.div_count + DIV_STEP;
			next_r.tick = 1'b0;
		end
		// ----------------------------------------
		// Scan sequencer
		// ----------------------------------------
		case (r.state)
			ADCPSC_IDLE: begin
				if (SCAN_ENABLE && scan_mask != '0) begin
					// Start from the lowest selected channel
					next_r.channel = adcpsc_first_ch(scan_mask);
					next_r.state = ADCPSC_SCAN;
				end
			end
			ADCPSC_SCAN: begin
				// An empty mask ends the scan rather than parking on a stale channel
				if (!SCAN_ENABLE || scan_mask == '0) begin
					next_r.state = ADCPSC_IDLE;
					next_r.channel = CH_ZERO;
				end else if (CONV_DONE) begin
					next_r.channel = adcpsc_next_ch(scan_mask, r.channel);
				end
			end
			default: begin
				// Illegal code after an upset: fall back to idle
				next_r.state = ADCPSC_IDLE;
				next_r.channel = CH_ZERO;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			r.pin_config <= RESET_CONFIG;
			r.scan_select <= RESET_CONFIG;
			r.div <= RESET_DIV;
			r.div_count <= RESET_DIV;
			r.tick <= 1'b0;
			r.channel <= CH_ZERO;
			r.state <= ADCPSC_IDLE;
			r.rdata <= '0;
		end else if (CE) begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign RDATA = r.rdata;
	assign PIN_DIGITAL_SELECT = r.pin_config[NUM_CH-1:0];
	assign PIN_ANALOG = ~r.pin_config[NUM_CH-1:0];
	assign BANDGAP_REF_ENABLE = ~r.pin_config[BANDGAP_BIT];
	assign SCAN_CHANNEL = r.channel;
	assign CONV_CLOCK_TICK = r.tick;

endmodule : adcpsc_top

// *** hw/adcpsc_pkg.sv ***
// Package: register map, field layout and scan constants for the converter pin and scan config
package adcpsc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int NUM_CH = 13;
	localparam int DIV_W = 8;
	localparam int CH_W = 4;
	localparam int SCAN_BUSY_BIT = 4;
	localparam logic [ADDR_W-1:0] ADDR_PIN_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_SCAN_SELECT = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CLOCK_DIV = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_SCAN_STATUS = 4'h3;
	localparam int BANDGAP_BIT = 15;
	localparam logic [DATA_W-1:0] IMPL_MASK = 16'h9FFF;
	localparam logic [DATA_W-1:0] RESET_CONFIG = 16'h0000;
	localparam logic [7:0] RESET_DIV = 8'h00;
	localparam logic [7:0] DIV_MAX = 8'h3F;
	localparam logic [7:0] DIV_STEP = 8'h01;
	localparam logic [3:0] BANDGAP_CHANNEL = 4'hF;
	localparam logic [3:0] CH_ZERO = 4'h0;
	typedef enum logic [1:0] {
		ADCPSC_IDLE = 2'b01,
		ADCPSC_SCAN = 2'b10
	} adcpsc_state_t;
endpackage : adcpsc_pkg

// *** bench/adcpsc_properties.sv ***
// Checker: port properties of the converter pin and scan config
`timescale 1ns/1ps
module adcpsc_properties (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	// Converter side
	input wire logic SCAN_ENABLE,
	input wire logic CONV_DONE,
	input wire logic [12:0] PIN_DIGITAL_SELECT,
	input wire logic [12:0] PIN_ANALOG,
	input wire logic BANDGAP_REF_ENABLE,
	input wire logic [3:0] SCAN_CHANNEL,
	input wire logic CONV_CLOCK_TICK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	ana_inv_a: assert property (PIN_ANALOG == ~PIN_DIGITAL_SELECT) else $error("mode");
	wr_pin_a: assert property (CE && WR && ADDR == 4'h0 |=>
		PIN_DIGITAL_SELECT == $past(WDATA[12:0]) && BANDGAP_REF_ENABLE == !$past(WDATA[15]))
		else $error("pin write");
	rd_pin_a: assert property (CE && RD && ADDR == 4'h0 |=>
		RDATA == {!BANDGAP_REF_ENABLE, 2'b00, PIN_DIGITAL_SELECT}) else $error("pin read");
	rd_scan_a: assert property (CE && RD && ADDR == 4'h1 |=> RDATA[14:13] == 2'b00)
		else $error("scan read");
	rst_clr_a: assert property ($rose(RSTN) |-> PIN_ANALOG == 13'h1FFF
		&& BANDGAP_REF_ENABLE && SCAN_CHANNEL == 4'h0) else $error("reset");
	scan_idle_a: assert property (CE && !SCAN_ENABLE |=> SCAN_CHANNEL == 4'h0)
		else $error("idle");
	scan_hold_a: assert property (CE && $past(CE) && SCAN_ENABLE && $past(SCAN_ENABLE)
		&& !CONV_DONE && !WR && !$past(WR) |=> $stable(SCAN_CHANNEL)) else $error("hold");
	ce_freeze_a: assert property (!CE |=> $stable(SCAN_CHANNEL) && $stable(RDATA)
		&& $stable(CONV_CLOCK_TICK)) else $error("freeze");
	cover property (SCAN_CHANNEL == 4'hF);
	cover property (CE && RD && ADDR == 4'h0);
	cover property ($rose(CONV_CLOCK_TICK));
endmodule : adcpsc_properties
bind adcpsc_top adcpsc_properties u_props (
	.CLK(CLK),
	.RSTN(RSTN),
	.CE(CE),
	.ADDR(ADDR),
	.WDATA(WDATA),
	.WR(WR),
	.RD(RD),
	.RDATA(RDATA),
	.SCAN_ENABLE(SCAN_ENABLE),
	.CONV_DONE(CONV_DONE),
	.PIN_DIGITAL_SELECT(PIN_DIGITAL_SELECT),
	.PIN_ANALOG(PIN_ANALOG),
	.BANDGAP_REF_ENABLE(BANDGAP_REF_ENABLE),
	.SCAN_CHANNEL(SCAN_CHANNEL),
	.CONV_CLOCK_TICK(CONV_CLOCK_TICK)
);

// *** bench/adc_pin_and_scan_config_test.sv ***
// Testbench: directed tests of the converter pin and scan config
`timescale 1ns/1ps
module adc_pin_and_scan_config_test;
	import adcpsc_pkg::*;
	logic CLK = 0, RSTN = 0, CE = 1, WR = 0, RD = 0, SCAN_ENABLE = 0, CONV_DONE = 0;
	logic [3:0] ADDR = 4'h0, SCAN_CHANNEL;
	logic [15:0] WDATA = 16'h0, RDATA;
	logic [12:0] PIN_DIGITAL_SELECT, PIN_ANALOG;
	logic BANDGAP_REF_ENABLE, CONV_CLOCK_TICK;
	logic [3:0] seq [3] = '{4'h2, 4'hF, 4'h1};
	int num_errors = 0, check_count = 0;
	adcpsc_top dut (
		.CLK(CLK),
		.RSTN(RSTN),
		.CE(CE),
		.ADDR(ADDR),
		.WDATA(WDATA),
		.WR(WR),
		.RD(RD),
		.RDATA(RDATA),
		.SCAN_ENABLE(SCAN_ENABLE),
		.CONV_DONE(CONV_DONE),
		.PIN_DIGITAL_SELECT(PIN_DIGITAL_SELECT),
		.PIN_ANALOG(PIN_ANALOG),
		.BANDGAP_REF_ENABLE(BANDGAP_REF_ENABLE),
		.SCAN_CHANNEL(SCAN_CHANNEL),
		.CONV_CLOCK_TICK(CONV_CLOCK_TICK)
	);
	initial forever #2.5 CLK = ~CLK;
	task chk(input logic [15:0] s, e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task cyc;
		@(posedge CLK);
		#1;
	endtask : cyc
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK) begin ADDR <= a; WDATA <= d; WR <= 1'b1; end
		@(posedge CLK) WR <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge CLK) begin ADDR <= a; RD <= 1'b1; end
		@(posedge CLK) RD <= 1'b0;
		#1 chk(RDATA, e);
	endtask : rd
	task test_done;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task t_reg;
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		chk(PIN_ANALOG, 16'h1FFF);
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'h9FFF);
		cyc;
		chk(RDATA, 16'h0000);
		chk(PIN_DIGITAL_SELECT, 16'h1FFF);
		chk(BANDGAP_REF_ENABLE, 16'h0000);
		wr(4'h0, 16'h01C1);
		rd(4'h5, 16'h0000);
		chk(PIN_ANALOG, 16'h1E3E);
		chk(PIN_DIGITAL_SELECT, 16'h01C1);
		chk(BANDGAP_REF_ENABLE, 16'h0001);
		wr(4'h1, 16'h7FFF);
		rd(4'h1, 16'h1FFF);
		wr(4'h1, 16'hFFFF);
		rd(4'h1, 16'h9FFF);
		$display("reg test done");
	endtask : t_reg
	task t_scan;
		wr(4'h1, 16'h8006);
		@(posedge CLK) SCAN_ENABLE <= 1'b1;
		cyc;
		cyc;
		chk(SCAN_CHANNEL, 4'h1);
		rd(4'h3, 16'h0011);
		foreach (seq[i]) begin
			@(posedge CLK) CONV_DONE <= 1'b1;
			@(posedge CLK) CONV_DONE <= 1'b0;
			cyc;
			chk(SCAN_CHANNEL, seq[i]);
		end
		@(posedge CLK) begin CE <= 1'b0; CONV_DONE <= 1'b1; end
		cyc;
		chk(SCAN_CHANNEL, 4'h1);
		@(posedge CLK) begin CE <= 1'b1; CONV_DONE <= 1'b0; SCAN_ENABLE <= 1'b0; end
		cyc;
		cyc;
		chk(SCAN_CHANNEL, 4'h0);
		$display("scan test done");
	endtask : t_scan
	task t_div(input logic [7:0] dv, input logic [15:0] e);
		int n;
		wr(4'h2, {8'h00, dv});
		// Read-back also lets the new code take hold before timing starts
		rd(4'h2, {8'h00, dv});
		for (n = 0; n < 300 && CONV_CLOCK_TICK !== 1'b1; n++) cyc;
		cyc;
		for (n = 1; n < 300 && CONV_CLOCK_TICK !== 1'b1; n++) cyc;
		if (n >= 300) begin
			num_errors++;
			test_done;
		end else begin
			chk(n[15:0], e);
			$display("div test done");
		end
	endtask : t_div
	task t_rst;
		wr(4'h0, 16'h8001);
		@(posedge CLK) RSTN <= 1'b0;
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		cyc;
		chk(PIN_ANALOG, 16'h1FFF);
		chk(BANDGAP_REF_ENABLE, 16'h0001);
		rd(4'h1, 16'h0000);
		$display("reset test done");
	endtask : t_rst
	initial begin
		repeat (20) @(posedge CLK);
		RSTN <= 1'b1;
		t_reg;
		t_scan;
		t_div(8'h00, 16'h0001);
		t_div(8'h03, 16'h0004);
		t_div(8'hFF, 16'h0040);
		t_rst;
		test_done;
	end
endmodule : adc_pin_and_scan_config_test
